// ===== pkg/doc_pkg.sv
// Purpose: Shared constants for the dual converter output control stage.
// Assumes: 200 MHz system clock; register bus with one-cycle read data.
// Notes:   All offsets are byte addresses of 32-bit words.
// Contract
// - Sleep pin or sleep bit enters power-down.
// - Power-down three-states every output driver.
// - Sleep pin low returns to normal operation.
// - Wake time grows with time spent down.
// - Standby keeps reference up, wakes faster.
// - Pin mode: format pin picks binary coding.
// - Pin mode: stabilizer pin enables duty stabilizer.
// - Serial mode: offset, twos or gray coding.
// - Hiz pin low drives data outputs.
// - Hiz pin high three-states data outputs.
// - Per-channel output disable bit at 0x14.
// - Samples appear twelve sample clocks later.
// - Data changes after sample clock rising edge.
// - Two capture strobes, polarity invertible.
// - Negative full scale gives minimum code.
// - Zero input gives mid code.
// - Top code without overrange flag.
// - Above range clamps high, flags overrange.
// - Below range clamps low, flags overrange.
package doc_pkg;
  localparam int ADC_BITS   = 12;
  localparam int RAW_BITS   = 14;
  localparam int CHANNELS   = 2;
  localparam int PIPE_DEPTH = 12;

  localparam logic [ADC_BITS-1:0] TC_MAX  = 12'h7ff;
  localparam logic [ADC_BITS-1:0] TC_MIN  = 12'h800;
  localparam logic [ADC_BITS-1:0] OB_FLIP = 12'h800;

  typedef enum logic [1:0] {
    DOC_CODE_OB   = 2'b00,
    DOC_CODE_TC   = 2'b01,
    DOC_CODE_GRAY = 2'b10
  } doc_code_e;

  typedef enum logic [1:0] {
    DOC_PW_RUN  = 2'b00,
    DOC_PW_DOWN = 2'b01,
    DOC_PW_STBY = 2'b10,
    DOC_PW_WAKE = 2'b11
  } doc_pw_e;

  localparam logic [7:0] OFS_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_POWER   = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0c;
  localparam logic [7:0] OFS_OUT_DIS = 8'h14;

  localparam int CFG_SERIAL   = 0;
  localparam int CFG_CODE_LO  = 1;
  localparam int CFG_STAB     = 3;
  localparam int CFG_STR_INV  = 4;
  localparam int CFG_WIDTH    = 5;
  localparam int PWR_SLEEP    = 0;
  localparam int PWR_STBY     = 1;
  localparam int ST_STATE_LO  = 0;
  localparam int ST_HIZ_PIN   = 2;
  localparam int ST_WAKE_LO   = 16;

  localparam logic [4:0] CFG_RESET     = 5'h00;
  localparam logic [1:0] PWR_RESET     = 2'h0;
  localparam logic [1:0] OUT_DIS_RESET = 2'h0;

  localparam int CLK_MHZ      = 200;
  localparam int TICK_NS      = 1000;
  localparam int TICK_CYCLES  = TICK_NS * CLK_MHZ / 1000;
  localparam int CNT_BITS     = 16;
  localparam logic [CNT_BITS-1:0] STBY_WAKE_TICKS = 16'h0002;
endpackage

// ===== pkg/doc_ch_if.sv
// Purpose: Carrier between the control top and one channel formatter.
// Assumes: One system clock domain.
// Notes:   The control side drives sample timing and coding.
`timescale 1ns/100ps
`default_nettype none
interface doc_ch_if;
  import doc_pkg::*;
  logic                sample_en;
  logic [RAW_BITS-1:0] raw;
  doc_code_e           coding;
  logic [ADC_BITS-1:0] code;
  logic                ovr;
  modport chan (input sample_en, raw, coding, output code, ovr);
  modport ctl  (output sample_en, raw, coding, input code, ovr);
endinterface
`default_nettype wire

// ===== hw/doc_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are quasi-static relative to their sampling moment.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/100ps
`default_nettype none
module doc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i, // System clock.
  input  wire logic         reset_i, // Asynchronous reset.
  input  wire logic [W-1:0] d_i,     // Asynchronous inputs.
  output logic      [W-1:0] q_o      // Synchronised outputs.
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ===== hw/doc_channel.sv
// Purpose: One channel: clamp, delay line and output coding.
// Assumes: raw is a signed core result that may exceed the 12-bit range.
// Notes:   Coding is applied at the end so a change takes effect at once.
`timescale 1ns/100ps
`default_nettype none
module doc_channel #(
  parameter int DEPTH = doc_pkg::PIPE_DEPTH
) (
  input wire logic clock_i, // System clock.
  input wire logic reset_i, // Asynchronous reset.
  doc_ch_if.chan   ch       // Channel carrier.
);
  import doc_pkg::*;

  logic signed [RAW_BITS-1:0] raw_s;
  wire  hi_clip = raw_s > $signed({{(RAW_BITS-ADC_BITS){1'b0}}, TC_MAX});
  wire  lo_clip = raw_s < $signed({{(RAW_BITS-ADC_BITS){1'b1}}, TC_MIN});
  wire  [ADC_BITS-1:0] tc_clamped = hi_clip ? TC_MAX :
                                    lo_clip ? TC_MIN :
                                    raw_s[ADC_BITS-1:0];
  wire  [ADC_BITS:0] stage_in = {hi_clip | lo_clip, tc_clamped};

  // Stage 0 loads on the capture edge and the top's output flop takes the
  // last stage, so a sample leaves twelve edges after it was taken.
  logic [ADC_BITS:0] stage_reg [DEPTH];

  assign raw_s = ch.raw;

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_reg[i] <= '0;
      end
    end else if (ch.sample_en) begin
      stage_reg[0] <= stage_in;
      for (int i = 1; i < DEPTH; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  wire [ADC_BITS-1:0] tc_out = stage_reg[DEPTH-1][ADC_BITS-1:0];
  wire [ADC_BITS-1:0] ob_out = tc_out ^ OB_FLIP;
  wire [ADC_BITS-1:0] gr_out = ob_out ^ (ob_out >> 1);

  assign ch.ovr  = stage_reg[DEPTH-1][ADC_BITS];
  assign ch.code = (ch.coding == DOC_CODE_TC)   ? tc_out :
                   (ch.coding == DOC_CODE_GRAY) ? gr_out : ob_out;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_clip_high;
    ch.sample_en && hi_clip |=> stage_reg[0] == {1'b1, TC_MAX};
  endproperty
  a_clip_high: assert property (p_clip_high)
    else $error("High clip did not give top code with flag.");

  property p_clip_low;
    ch.sample_en && lo_clip |=> stage_reg[0] == {1'b1, TC_MIN};
  endproperty
  a_clip_low: assert property (p_clip_low)
    else $error("Low clip did not give bottom code with flag.");

  property p_in_range;
    ch.sample_en && !hi_clip && !lo_clip |=> !stage_reg[0][ADC_BITS];
  endproperty
  a_in_range: assert property (p_in_range)
    else $error("Overrange flag set for an in-range sample.");

  property p_ob_tc;
    ch.coding == DOC_CODE_OB |-> ch.code[ADC_BITS-1] != tc_out[ADC_BITS-1]
      && ch.code[ADC_BITS-2:0] == tc_out[ADC_BITS-2:0];
  endproperty
  a_ob_tc: assert property (p_ob_tc)
    else $error("Offset binary is not twos complement with flipped sign.");

  property p_gray_msb;
    ch.coding == DOC_CODE_GRAY |-> ch.code[ADC_BITS-1] == ob_out[ADC_BITS-1];
  endproperty
  a_gray_msb: assert property (p_gray_msb)
    else $error("Gray code top bit differs from offset binary.");

  c_clip_high: cover property (ch.sample_en && hi_clip);
  c_gray: cover property (ch.coding == DOC_CODE_GRAY && ch.sample_en);
endmodule
`default_nettype wire

// ===== hw/doc_top.sv
// Purpose: Output control of a dual 12-bit converter: coding, delay,
//          capture strobes, three-state and power modes.
// Assumes: The sample clock arrives as a pin and is oversampled here.
// Notes:   Wake timing counts 1 us ticks from a divider.
`timescale 1ns/100ps
`default_nettype none
module doc_top #(
  parameter int WAKE_SHIFT = 2
) (
  input  wire logic                                        clock_i,                 // System clock.
  input  wire logic                                        reset_i,                 // Async reset.
  input  wire logic                                        sample_clock_i,          // Sample clock pin.
  input  wire logic                                        sleep_request_i,         // Sleep pin.
  input  wire logic                                        output_hiz_pin_i,        // Hiz pin.
  input  wire logic                                        format_select_pin_i,     // Format pin.
  input  wire logic                                        stabilizer_select_pin_i, // Stab pin.
  input  wire logic [doc_pkg::CHANNELS-1:0][doc_pkg::RAW_BITS-1:0] raw_i,          // Core results.
  input  wire logic [7:0]                                  reg_addr_i,              // Byte address.
  input  wire logic [31:0]                                 reg_wdata_i,             // Write data.
  input  wire logic                                        reg_write_i,             // Write strobe.
  input  wire logic                                        reg_read_i,              // Read strobe.
  output logic      [31:0]                                 reg_rdata_o,             // Read data.
  output logic      [doc_pkg::CHANNELS-1:0][doc_pkg::ADC_BITS-1:0] data_o,         // Output codes.
  output logic      [doc_pkg::CHANNELS-1:0]                overrange_o,             // Range flags.
  output logic      [doc_pkg::CHANNELS-1:0]                data_oe_n_o,             // Data enables.
  output logic      [1:0]                                  capture_strobe_out_o,    // Strobes.
  output logic                                             strobe_oe_n_o,           // Strobe enable.
  output logic                                             duty_stabilizer_o        // Stabilizer on.
);
  import doc_pkg::*;

  localparam int SYNC_W = 5 + CHANNELS * RAW_BITS;
  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // Raw data is synchronised with the pins; the core holds it stable
  // for many system clocks around each sample edge, so no word tears.
  logic [SYNC_W-1:0] sync_q;
  doc_sync #(.W(SYNC_W)) u_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .d_i     ({raw_i, stabilizer_select_pin_i, format_select_pin_i,
                output_hiz_pin_i, sleep_request_i, sample_clock_i}),
    .q_o     (sync_q)
  );

  wire sclk_s   = sync_q[0];
  wire sleep_s  = sync_q[1];
  wire hiz_s    = sync_q[2];
  wire fmt_s    = sync_q[3];
  wire stab_s   = sync_q[4];
  wire [CHANNELS-1:0][RAW_BITS-1:0] raw_s = sync_q[SYNC_W-1:5];

  logic                sclk_d_reg;
  logic [CFG_WIDTH-1:0] cfg_reg;
  logic [1:0]          pwr_reg;
  logic [CHANNELS-1:0] out_dis_reg;
  logic [TICK_W-1:0]   tick_cnt_reg;
  logic [CNT_BITS-1:0] down_cnt_reg;
  logic [CNT_BITS-1:0] down_cnt_next;
  logic [CNT_BITS-1:0] wake_cnt_reg;
  logic [CNT_BITS-1:0] wake_cnt_next;
  doc_pw_e             pw_state_reg;
  doc_pw_e             pw_state_next;

  wire sample_edge = sclk_s & ~sclk_d_reg;
  wire tick        = tick_cnt_reg == TICK_LAST;

  // Register decode.
  wire wr_cfg = reg_write_i && reg_addr_i == OFS_CONFIG;
  wire wr_pwr = reg_write_i && reg_addr_i == OFS_POWER;
  wire wr_dis = reg_write_i && reg_addr_i == OFS_OUT_DIS;
  wire serial_mode = cfg_reg[CFG_SERIAL];
  wire str_inv     = cfg_reg[CFG_STR_INV] & serial_mode;
  wire [1:0] cfg_code = cfg_reg[CFG_CODE_LO+1:CFG_CODE_LO];
  wire doc_code_e coding_sel = serial_mode ? doc_code_e'(cfg_code) :
                               fmt_s ? DOC_CODE_TC : DOC_CODE_OB;
  wire stab_next   = serial_mode ? cfg_reg[CFG_STAB] : stab_s;

  wire sleep_all = sleep_s | pwr_reg[PWR_SLEEP];
  wire stby_req  = pwr_reg[PWR_STBY];
  wire pw_hiz    = pw_state_reg != DOC_PW_RUN;

  wire [CNT_BITS-1:0] down_scaled = down_cnt_reg >> WAKE_SHIFT;
  wire [CNT_BITS-1:0] down_wake   = (down_scaled == '0) ?
                                    CNT_BITS'(1) : down_scaled;

  wire [31:0] status_word = {wake_cnt_reg, 13'h0000, hiz_s,
                             pw_state_reg};
  wire [31:0] rd_mux =
    (reg_addr_i == OFS_CONFIG)  ? {27'h000_0000, cfg_reg} :
    (reg_addr_i == OFS_POWER)   ? {30'h0000_0000, pwr_reg} :
    (reg_addr_i == OFS_STATUS)  ? status_word :
    (reg_addr_i == OFS_OUT_DIS) ? {30'h0000_0000, out_dis_reg} :
    32'h0000_0000;

  // Power state machine.
  always_comb begin
    pw_state_next = pw_state_reg;
    wake_cnt_next = wake_cnt_reg;
    case (pw_state_reg)
      DOC_PW_RUN: begin
        if (sleep_all) begin
          pw_state_next = DOC_PW_DOWN;
        end else if (stby_req) begin
          pw_state_next = DOC_PW_STBY;
        end
      end
      DOC_PW_DOWN: begin
        if (!sleep_all && stby_req) begin
          pw_state_next = DOC_PW_STBY;
        end else if (!sleep_all) begin
          pw_state_next = DOC_PW_WAKE;
          wake_cnt_next = down_wake;
        end
      end
      DOC_PW_STBY: begin
        if (sleep_all) begin
          pw_state_next = DOC_PW_DOWN;
        end else if (!stby_req) begin
          pw_state_next = DOC_PW_WAKE;
          wake_cnt_next = STBY_WAKE_TICKS;
        end
      end
      DOC_PW_WAKE: begin
        if (sleep_all) begin
          pw_state_next = DOC_PW_DOWN;
        end else if (stby_req) begin
          pw_state_next = DOC_PW_STBY;
        end else if (wake_cnt_reg == '0) begin
          pw_state_next = DOC_PW_RUN;
        end else if (tick) begin
          wake_cnt_next = wake_cnt_reg - CNT_BITS'(1);
        end
      end
      default: begin
        pw_state_next = DOC_PW_DOWN;
      end
    endcase
  end

  // Time spent down saturates rather than wraps, so a long sleep never
  // turns into a short wake.
  always_comb begin
    down_cnt_next = down_cnt_reg;
    if (pw_state_reg != DOC_PW_DOWN) begin
      down_cnt_next = '0;
    end else if (tick && down_cnt_reg != '1) begin
      down_cnt_next = down_cnt_reg + CNT_BITS'(1);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick ? '0 : tick_cnt_reg + TICK_W'(1);
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pw_state_reg <= DOC_PW_RUN;
      wake_cnt_reg <= '0;
      down_cnt_reg <= '0;
    end else begin
      pw_state_reg <= pw_state_next;
      wake_cnt_reg <= wake_cnt_next;
      down_cnt_reg <= down_cnt_next;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_reg     <= CFG_RESET;
      pwr_reg     <= PWR_RESET;
      out_dis_reg <= OUT_DIS_RESET;
      reg_rdata_o <= '0;
    end else begin
      if (wr_cfg) cfg_reg <= reg_wdata_i[CFG_WIDTH-1:0];
      if (wr_pwr) pwr_reg <= reg_wdata_i[1:0];
      if (wr_dis) out_dis_reg <= reg_wdata_i[CHANNELS-1:0];
      reg_rdata_o <= reg_read_i ? rd_mux : 32'h0000_0000;
    end
  end

  // Channels, one formatter each.
  doc_ch_if ch_if [CHANNELS] ();
  logic [CHANNELS-1:0][ADC_BITS-1:0] ch_code;
  logic [CHANNELS-1:0]               ch_ovr;

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    assign ch_if[c].sample_en = sample_edge;
    assign ch_if[c].raw       = raw_s[c];
    assign ch_if[c].coding    = coding_sel;
    assign ch_code[c]         = ch_if[c].code;
    assign ch_ovr[c]          = ch_if[c].ovr;
    doc_channel u_channel (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .ch      (ch_if[c])
    );

    always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
        data_o[c]      <= '0;
        overrange_o[c] <= 1'b0;
        data_oe_n_o[c] <= 1'b1;
      end else begin
        if (sample_edge) begin
          data_o[c]      <= ch_code[c];
          overrange_o[c] <= ch_ovr[c];
        end
        data_oe_n_o[c] <= pw_hiz | hiz_s | out_dis_reg[c];
      end
    end
  end

  // The strobe rises mid-way through each data word: data moves on the
  // sample rising edge, the strobe on its falling edge.
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_d_reg           <= 1'b0;
      capture_strobe_out_o <= 2'b00;
      strobe_oe_n_o        <= 1'b1;
      duty_stabilizer_o    <= 1'b0;
    end else begin
      sclk_d_reg           <= sclk_s;
      capture_strobe_out_o <= {2{~sclk_s ^ str_inv}};
      strobe_oe_n_o        <= pw_hiz;
      duty_stabilizer_o    <= stab_next;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_sleep_enter;
    sleep_all |=> pw_state_reg == DOC_PW_DOWN;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter)
    else $error("Sleep request did not enter power-down.");

  property p_down_hiz;
    pw_state_reg != DOC_PW_RUN |=> &data_oe_n_o && strobe_oe_n_o;
  endproperty
  a_down_hiz: assert property (p_down_hiz)
    else $error("Output driven while not running.");

  property p_wake_exit;
    pw_state_reg == DOC_PW_DOWN && !sleep_all && !stby_req
      |=> pw_state_reg == DOC_PW_WAKE && wake_cnt_reg == $past(down_wake);
  endproperty
  a_wake_exit: assert property (p_wake_exit)
    else $error("Leaving power-down did not start the scaled wake count.");

  property p_wake_scale;
    pw_state_reg == DOC_PW_DOWN && tick && down_cnt_reg == 16'h0004
      |-> down_wake == (16'h0004 >> WAKE_SHIFT);
  endproperty
  a_wake_scale: assert property (p_wake_scale)
    else $error("Wake count does not scale with time down.");

  property p_stby_wake;
    pw_state_reg == DOC_PW_STBY && !sleep_all && !stby_req
      |=> wake_cnt_reg == STBY_WAKE_TICKS;
  endproperty
  a_stby_wake: assert property (p_stby_wake)
    else $error("Standby exit did not load the short wake count.");

  property p_pin_format;
    !serial_mode |-> coding_sel == (fmt_s ? DOC_CODE_TC : DOC_CODE_OB);
  endproperty
  a_pin_format: assert property (p_pin_format)
    else $error("Pin mode coding does not follow the format pin.");

  property p_pin_stab;
    !serial_mode |=> duty_stabilizer_o == $past(stab_s);
  endproperty
  a_pin_stab: assert property (p_pin_stab)
    else $error("Stabilizer output does not follow its pin.");

  property p_drive;
    pw_state_reg == DOC_PW_RUN && !hiz_s && out_dis_reg == '0
      |=> data_oe_n_o == '0;
  endproperty
  a_drive: assert property (p_drive)
    else $error("Data outputs not driven in normal operation.");

  property p_hiz_pin;
    hiz_s |=> &data_oe_n_o;
  endproperty
  a_hiz_pin: assert property (p_hiz_pin)
    else $error("Hiz pin high but data outputs driven.");

  property p_ch_dis;
    out_dis_reg[0] && !hiz_s && pw_state_reg == DOC_PW_RUN
      |=> data_oe_n_o[0] && !data_oe_n_o[1] == !$past(out_dis_reg[1]);
  endproperty
  a_ch_dis: assert property (p_ch_dis)
    else $error("Channel disable not independent per channel.");

  property p_data_edge;
    !sample_edge |=> $stable(data_o) && $stable(overrange_o);
  endproperty
  a_data_edge: assert property (p_data_edge)
    else $error("Output data moved without a sample edge.");

  property p_strobe;
    1'b1 |=> capture_strobe_out_o[0] == ($past(~sclk_s) ^ $past(str_inv));
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("Capture strobe polarity wrong.");

  c_sleep_cycle: cover property (pw_state_reg == DOC_PW_WAKE ##1
                                 pw_state_reg == DOC_PW_RUN);
  c_standby: cover property (pw_state_reg == DOC_PW_STBY);
  c_overrange: cover property (sample_edge && |ch_ovr);
endmodule
`default_nettype wire

// ===== verification/doc_capture_model.sv
// Purpose: Receiver that latches both channels' codes on the strobe.
// Assumes: Codes are settled at the active strobe edge.
// Notes:   Inverted polarity moves capture to the falling strobe edge.
`timescale 1ns/100ps
`default_nettype none
module doc_capture_model (
  input  wire logic        inv_i,    // Strobe polarity inverted.
  input  wire logic [1:0]  strobe_i, // Capture strobes.
  input  wire logic [23:0] data_i,   // Both channels' codes.
  output logic      [23:0] q_o       // Latched codes.
);
  wire logic cap = strobe_i[0] ^ inv_i;
  always @(posedge cap) begin
    q_o <= data_i;
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Purpose: Self-checking bench for the dual converter output stage.
// Assumes: Sample clock pin of 64 ns, unrelated in phase to clock_i.
// Notes:   Wake shift is zero so wake time tracks time spent down.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import doc_pkg::*;
  logic             clock_i = 0, reset_i = 1, sample_clock_i = 0, inv = 0;
  logic             sleep_request_i = 0, output_hiz_pin_i = 0;
  logic             format_select_pin_i = 0, stabilizer_select_pin_i = 0;
  logic [1:0][13:0] raw_i = '0;
  logic [7:0]       reg_addr_i = '0;
  logic [31:0]      reg_wdata_i = '0, reg_rdata_o;
  logic             reg_write_i = 0, reg_read_i = 0;
  logic [1:0][11:0] data_o;
  logic [1:0]       overrange_o, data_oe_n_o, capture_strobe_out_o;
  logic             strobe_oe_n_o, duty_stabilizer_o;
  logic [23:0]      cap_q;
  int               miscompares = 0, total_checks = 0;
  initial forever #2.5 clock_i = ~clock_i;
  initial begin
    #7;
    forever #32 sample_clock_i = ~sample_clock_i;
  end
  doc_top #(.WAKE_SHIFT(0)) i_doc_top (.clock_i(clock_i), .reset_i(reset_i),
    .sample_clock_i(sample_clock_i), .sleep_request_i(sleep_request_i),
    .output_hiz_pin_i(output_hiz_pin_i), .raw_i(raw_i),
    .format_select_pin_i(format_select_pin_i),
    .stabilizer_select_pin_i(stabilizer_select_pin_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .data_o(data_o), .overrange_o(overrange_o),
    .data_oe_n_o(data_oe_n_o), .capture_strobe_out_o(capture_strobe_out_o),
    .strobe_oe_n_o(strobe_oe_n_o), .duty_stabilizer_o(duty_stabilizer_o));
  doc_capture_model i_doc_capture_model (.inv_i(inv),
    .strobe_i(capture_strobe_out_o), .data_i(data_o), .q_o(cap_q));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic ck(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_write_i <= 1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_write_i <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e,
                     input string n);
    @(posedge clock_i);
    reg_read_i <= 1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_read_i <= 0;
    #1 chk(n, e, reg_rdata_o & m);
  endtask
  // Result is the range flag above the 12-bit code.
  function automatic logic [12:0] expc(input int v, input int m);
    logic [11:0] t, b;
    t = v > 2047 ? TC_MAX : (v < -2048 ? TC_MIN : v[11:0]);
    b = t ^ OB_FLIP;
    expc[11:0] = m == 1 ? t : (m == 2 ? b ^ (b >> 1) : b);
    expc[12] = v > 2047 || v < -2048;
  endfunction
  task automatic settle;
    repeat (14) @(posedge sample_clock_i);
    ck(6);
  endtask
  task automatic t_coding;
    int vals[6] = '{-2048, 0, 2047, 2048, -2049, 5};
    int cfgs[5] = '{0, 0, 1, 3, 21};
    int mode[5] = '{0, 1, 0, 1, 2};
    logic [12:0] e0, e1;
    for (int k = 0; k < 5; k++) begin
      wr(OFS_CONFIG, 32'(cfgs[k]));
      @(posedge clock_i);
      format_select_pin_i <= (k == 1);
      inv <= (k == 4);
      for (int i = 0; i < 6; i++) begin
        e0 = expc(vals[i], mode[k]);
        e1 = expc(vals[(i+1)%6], mode[k]);
        @(posedge clock_i) raw_i <= {14'(vals[(i+1)%6]), 14'(vals[i])};
        settle();
        chk("codes", {e1[11:0], e0[11:0]}, data_o);
        chk("ovr", {e1[12], e0[12]}, overrange_o);
        chk("capture", data_o, cap_q);
        chk("strobes", 0, ^capture_strobe_out_o);
      end
    end
  endtask
  task automatic t_latency;
    wr(OFS_CONFIG, 0);
    @(posedge clock_i) raw_i <= {14'd100, 14'd100};
    settle();
    @(negedge sample_clock_i);
    @(posedge clock_i) raw_i <= {14'd7, 14'd7};
    repeat (12) @(posedge sample_clock_i);
    ck(5);
    chk("early", expc(100, 0), {overrange_o[0], data_o[0]});
    @(posedge sample_clock_i);
    ck(5);
    chk("late", expc(7, 0), {overrange_o[1], data_o[1]});
  endtask
  task automatic t_outputs;
    @(posedge clock_i) output_hiz_pin_i <= 1;
    ck(6);
    chk("oe_hiz", 2'b11, {strobe_oe_n_o, data_oe_n_o});
    rdc(OFS_STATUS, 32'h0000_0004, 32'h0000_0004, "st_hiz");
    @(posedge clock_i) output_hiz_pin_i <= 0;
    ck(6);
    chk("oe_run", 0, data_oe_n_o);
    for (int c = 1; c < 4; c++) begin
      wr(OFS_OUT_DIS, 32'(c));
      ck(3);
      chk("oe_dis", c, data_oe_n_o);
      rdc(OFS_OUT_DIS, 32'hffff_ffff, c, "out_dis");
    end
    wr(OFS_OUT_DIS, 0);
    rdc(8'h20, 32'hffff_ffff, 0, "unmapped");
  endtask
  task automatic t_stab;
    @(posedge clock_i) stabilizer_select_pin_i <= 1;
    ck(6);
    chk("duty_pin", 1, duty_stabilizer_o);
    wr(OFS_CONFIG, 32'h0000_0009);
    @(posedge clock_i) stabilizer_select_pin_i <= 0;
    ck(6);
    chk("duty_ser", 1, duty_stabilizer_o);
    wr(OFS_CONFIG, 0);
    ck(3);
    chk("duty_off", 0, duty_stabilizer_o);
  endtask
  task automatic down(input int m, input int us, output int w);
    if (m == 0) @(posedge clock_i) sleep_request_i <= 1;
    else wr(OFS_POWER, 32'(m));
    ck(6);
    chk("oe_down", 3'b111, {strobe_oe_n_o, data_oe_n_o});
    rdc(OFS_STATUS, 3, m == 2 ? 2 : 1, "state");
    repeat (us * TICK_CYCLES) @(posedge clock_i);
    if (m == 0) @(posedge clock_i) sleep_request_i <= 0;
    else wr(OFS_POWER, 0);
    w = 0;
    while (data_oe_n_o !== 2'b00 && w < 20000) begin
      ck(1);
      w++;
    end
    chk("woke", 0, data_oe_n_o);
    rdc(OFS_STATUS, 3, 0, "run");
  endtask
  task automatic t_power;
    int w1, w2, w3;
    down(0, 2, w1);
    down(1, 16, w2);
    down(2, 16, w3);
    chk("wake_grows", 1, w2 > w1 + 800);
    chk("stby_fast", 1, w3 < w2);
  endtask
  initial begin
    repeat (4) @(posedge clock_i);
    reset_i <= 0;
    t_coding();
    t_latency();
    t_outputs();
    t_stab();
    t_power();
    tally_and_finish();
  end
  // The run needs about 90 us; the limit leaves ample room.
  initial begin
    #300000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
